// ==== rtl/drh_host.sv ====
// host controller for a 64k x 1 multiplexed-address dram
// assumes the user side is synchronous to sys_clk_i and read data is sampled on that clock
`timescale 1ns/10ps
`default_nettype none

// How it works
// - after reset wait 100 us, then eight row-strobe cycles before any access
// - after over 2 ms without strobes, repeat eight row-strobe wake cycles
// - row field then column field on eight address pins, each under its strobe
// - column strobe follows row strobe inside the row-to-column delay window
// - page mode presents a new column per column strobe with row strobe held
// - refresh drives a 7-bit row; the top row address bit is unused
// - column strobe stays high during a row-only refresh cycle
// - a read starts with a valid row address as the row strobe falls
// - strobes keep their minimum widths; row strobe precharges before next cycle
// - column strobe may overlap the next cycle by at most 10 ns
// - write strobe stays high around the whole column strobe of a read
// - refresh every row of 128 within 2 ms, one row per 15.6 us
// - page mode never holds the row strobe low beyond 10 us
module drh_host #(
  parameter int POWERUP_COUNT = drh_pkg::POWERUP_CYCLES,
  parameter int IDLE_COUNT = drh_pkg::IDLE_LIMIT_CYCLES,
  parameter int REFRESH_COUNT = drh_pkg::REFRESH_CYCLES,
  parameter int PAGE_COUNT = drh_pkg::PAGE_MAX_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  input wire drh_pkg::drh_req_type req_i,
  input wire logic page_i,
  output logic req_ready_o,
  output logic rd_valid_o,
  output logic rd_data_o,
  output logic init_done_o,
  output logic dram_ras_n_o,
  output logic dram_cas_n_o,
  output logic dram_write_n_o,
  output logic [7:0] dram_addr_o,
  output logic dram_data_o,
  input wire logic dram_q_i
);

  localparam int TW = drh_pkg::TIMER_BITS;
  localparam int BW = 24;

  drh_pkg::drh_state_type state;
  drh_pkg::drh_state_type next_state;
  drh_pkg::drh_req_type cur;
  drh_pkg::drh_pins_type pins;
  drh_pkg::drh_pins_type next_pins;
  logic [3:0] wake_count;
  logic [BW-1:0] idle_count;
  logic [BW-1:0] refresh_count;
  logic [BW-1:0] page_count;
  logic [drh_pkg::REFRESH_ROW_BITS-1:0] refresh_row;
  logic refresh_due;
  logic init_done;
  logic timer_load;
  logic [TW-1:0] timer_value;
  logic timer_done;
  logic pause_loaded;

  drh_timer #(
    .WIDTH(TW)
  ) u_timer (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .load_i(timer_load),
    .value_i(timer_value),
    .done_o(timer_done)
  );

  // decode of what the state machine may start
  wire logic idle_ready = (state == drh_pkg::ST_IDLE) && timer_done;
  wire logic start_refresh = idle_ready && refresh_due;
  wire logic start_access = idle_ready && !refresh_due && req_valid_i;
  wire logic idle_expired = (idle_count >= BW'(IDLE_COUNT));
  wire logic start_wake = idle_ready && !refresh_due && !req_valid_i && idle_expired;
  wire logic page_room = (page_count < BW'(PAGE_COUNT - 8));
  wire logic page_go = page_i && req_valid_i && !refresh_due && page_room
    && (req_i.row == cur.row);
  // read data is captured on the same edge that raises the column strobe
  wire logic read_sample = (state == drh_pkg::ST_COL_HOLD) && timer_done && !cur.write;
  // refresh flag as it stands after this edge; ready stays low whenever a refresh would win
  wire logic refresh_tick = (refresh_count >= BW'(REFRESH_COUNT - 1));
  wire logic next_refresh_due = refresh_tick ? init_done : (refresh_due && !start_refresh);

  // state sequencing
  always_comb begin
    next_state = state;
    timer_load = 1'b0;
    timer_value = '0;
    next_pins = pins;
    case (state)
      drh_pkg::ST_POWERUP: begin
        if (!pause_loaded) begin
          timer_load = 1'b1;
          timer_value = TW'(POWERUP_COUNT);
        end else if (timer_done) begin
          next_state = drh_pkg::ST_WAKE_LOW;
          next_pins.ras_n = 1'b0;
          timer_load = 1'b1;
          timer_value = TW'(drh_pkg::RAS_MIN_CYCLES);
        end
      end
      drh_pkg::ST_WAKE_LOW: begin
        if (timer_done) begin
          next_state = drh_pkg::ST_WAKE_HIGH;
          next_pins.ras_n = 1'b1;
          timer_load = 1'b1;
          timer_value = TW'(drh_pkg::PRECHARGE_CYCLES);
        end
      end
      drh_pkg::ST_WAKE_HIGH: begin
        if (timer_done) begin
          if (wake_count == 4'(drh_pkg::WAKE_CYCLES - 1)) begin
            next_state = drh_pkg::ST_IDLE;
          end else begin
            next_state = drh_pkg::ST_WAKE_LOW;
            next_pins.ras_n = 1'b0;
            timer_load = 1'b1;
            timer_value = TW'(drh_pkg::RAS_MIN_CYCLES);
          end
        end
      end
      drh_pkg::ST_IDLE: begin
        if (start_refresh) begin
          next_state = drh_pkg::ST_REFRESH;
          next_pins.addr = {1'b0, refresh_row};
          next_pins.ras_n = 1'b0;
          next_pins.cas_n = 1'b1;
          timer_load = 1'b1;
          timer_value = TW'(drh_pkg::RAS_MIN_CYCLES);
        end else if (start_access) begin
          next_state = drh_pkg::ST_ROW;
          next_pins.addr = req_i.row;
          next_pins.ras_n = 1'b0;
          next_pins.write_n = ~req_i.write;
          next_pins.data_in = req_i.data;
          timer_load = 1'b1;
          timer_value = TW'(drh_pkg::ROW_HOLD_CYCLES);
        end else if (start_wake) begin
          next_state = drh_pkg::ST_WAKE_LOW;
          next_pins.ras_n = 1'b0;
          timer_load = 1'b1;
          timer_value = TW'(drh_pkg::RAS_MIN_CYCLES);
        end
      end
      drh_pkg::ST_ROW: begin
        // address switches to column one cycle before the column strobe falls
        if (timer_done) begin
          next_state = drh_pkg::ST_COL;
          next_pins.addr = cur.col;
        end
      end
      drh_pkg::ST_COL: begin
        next_state = drh_pkg::ST_COL_HOLD;
        next_pins.cas_n = 1'b0;
        timer_load = 1'b1;
        // hold long enough for both widths and the row-strobe access time
        timer_value = TW'(drh_pkg::ROW_STROBE_ACCESS_NS / drh_pkg::CLK_PERIOD_NS + 1);
      end
      drh_pkg::ST_COL_HOLD: begin
        if (timer_done) begin
          next_pins.cas_n = 1'b1;
          next_state = drh_pkg::ST_PAGE_WAIT;
        end
      end
      drh_pkg::ST_PAGE_WAIT: begin
        if (page_go) begin
          next_state = drh_pkg::ST_CAS_PRE;
          next_pins.write_n = ~req_i.write;
          next_pins.data_in = req_i.data;
          timer_load = 1'b1;
          timer_value = TW'(drh_pkg::CAS_PRECHARGE_CYCLES - 1);
        end else begin
          next_state = drh_pkg::ST_PRECHARGE;
          next_pins.ras_n = 1'b1;
          next_pins.write_n = 1'b1;
          timer_load = 1'b1;
          timer_value = TW'(drh_pkg::PRECHARGE_CYCLES);
        end
      end
      drh_pkg::ST_CAS_PRE: begin
        if (timer_done) begin
          next_state = drh_pkg::ST_COL;
          next_pins.addr = cur.col;
        end
      end
      drh_pkg::ST_REFRESH: begin
        if (timer_done) begin
          next_state = drh_pkg::ST_PRECHARGE;
          next_pins.ras_n = 1'b1;
          timer_load = 1'b1;
          timer_value = TW'(drh_pkg::PRECHARGE_CYCLES);
        end
      end
      drh_pkg::ST_PRECHARGE: begin
        if (timer_done) begin
          next_state = drh_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = drh_pkg::ST_POWERUP;
      end
    endcase
  end

  // state, pins and request capture
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      state <= drh_pkg::ST_POWERUP;
      pins <= '{ras_n: 1'b1, cas_n: 1'b1, write_n: 1'b1, addr: 8'h00, data_in: 1'b0};
      cur <= '0;
    end else begin
      state <= next_state;
      pins <= next_pins;
      if (start_access || (state == drh_pkg::ST_PAGE_WAIT && page_go)) begin
        cur <= req_i;
      end
    end
  end

  // the power-up pause is loaded once out of reset through a separate path
  wire logic first_cycle = (state == drh_pkg::ST_POWERUP) && !init_done && (wake_count == 4'h0);

  // wake cycle counter and init flag
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wake_count <= 4'h0;
      init_done <= 1'b0;
    end else if (state == drh_pkg::ST_WAKE_HIGH && timer_done) begin
      wake_count <= wake_count + 4'h1;
      if (wake_count == 4'(drh_pkg::WAKE_CYCLES - 1)) begin
        init_done <= 1'b1;
        wake_count <= 4'h0;
      end
    end
  end

  // inactivity, refresh and row-active timers; wide counts live here, not in drh_timer
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      idle_count <= '0;
      refresh_count <= '0;
      page_count <= '0;
      refresh_row <= '0;
      refresh_due <= 1'b0;
    end else begin
      idle_count <= pins.ras_n ? (idle_expired ? idle_count : idle_count + BW'(1)) : '0;
      page_count <= pins.ras_n ? '0 : page_count + BW'(1);
      if (start_refresh) begin
        refresh_due <= 1'b0;
        refresh_row <= refresh_row + 7'h01;
      end
      if (refresh_count >= BW'(REFRESH_COUNT - 1)) begin
        refresh_count <= '0;
        refresh_due <= init_done;
      end else begin
        refresh_count <= refresh_count + BW'(1);
      end
    end
  end

  // unlatched dram output is caught while the column strobe is still low
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rd_valid_o <= 1'b0;
      rd_data_o <= 1'b0;
    end else begin
      rd_valid_o <= read_sample;
      if (read_sample) begin
        rd_data_o <= dram_q_i;
      end
    end
  end

  // ready only when a new request would be taken on the next edge
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      req_ready_o <= 1'b0;
    end else begin
      req_ready_o <= (next_state == drh_pkg::ST_IDLE) && init_done && !next_refresh_due;
    end
  end

  // power-up pause: timer loaded from a second path on the very first cycle
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pause_loaded <= 1'b0;
    end else if (first_cycle) begin
      pause_loaded <= 1'b1;
    end
  end

  assign init_done_o = init_done;
  assign dram_ras_n_o = pins.ras_n;
  assign dram_cas_n_o = pins.cas_n;
  assign dram_write_n_o = pins.write_n;
  assign dram_addr_o = pins.addr;
  assign dram_data_o = pins.data_in;

endmodule // drh_host
`default_nettype wire

// ==== include/drh_pkg.sv ====
// package for the 64k x 1 dram host controller: timing counts, states and carriers
// assumes a 25 MHz system clock (40 ns period) and a 120 ns speed grade part
package drh_pkg;

  localparam int CLK_PERIOD_NS = 40;
  // timing figures in their own units
  localparam int POWERUP_PAUSE_US = 100;
  localparam int IDLE_LIMIT_MS = 2;
  localparam int REFRESH_INTERVAL_NS = 15600;
  localparam int PAGE_MAX_ACTIVE_US = 10;
  localparam int RAS_MIN_WIDTH_NS = 120;
  localparam int CAS_MIN_WIDTH_NS = 60;
  localparam int ROW_PRECHARGE_NS = 100;
  localparam int ROW_ADDRESS_HOLD_NS = 15;
  localparam int ROW_STROBE_ACCESS_NS = 120;
  localparam int COLUMN_STROBE_ACCESS_NS = 60;
  localparam int COLUMN_PRECHARGE_NS = 50;
  // least times round up, longest round down
  localparam int POWERUP_CYCLES = (POWERUP_PAUSE_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int IDLE_LIMIT_CYCLES = (IDLE_LIMIT_MS * 1000000) / CLK_PERIOD_NS;
  localparam int REFRESH_CYCLES = REFRESH_INTERVAL_NS / CLK_PERIOD_NS;
  localparam int PAGE_MAX_CYCLES = (PAGE_MAX_ACTIVE_US * 1000) / CLK_PERIOD_NS;
  localparam int RAS_MIN_CYCLES = (RAS_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAS_MIN_CYCLES = (CAS_MIN_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRECHARGE_CYCLES = (ROW_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ROW_HOLD_CYCLES = (ROW_ADDRESS_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAS_PRECHARGE_CYCLES =
    (COLUMN_PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WAKE_CYCLES = 8;
  localparam int ROW_BITS = 8;
  localparam int COL_BITS = 8;
  localparam int REFRESH_ROW_BITS = 7;
  localparam int TIMER_BITS = 16;

  // one access request from the user side
  typedef struct packed {
    logic write;
    logic [ROW_BITS-1:0] row;
    logic [COL_BITS-1:0] col;
    logic data;
  } drh_req_type;

  // pin group towards the dram
  typedef struct packed {
    logic ras_n;
    logic cas_n;
    logic write_n;
    logic [7:0] addr;
    logic data_in;
  } drh_pins_type;

  // gray-coded along init -> idle -> row -> col -> hold -> page wait
  typedef enum logic [3:0] {
    ST_POWERUP = 4'h0,
    ST_WAKE_LOW = 4'h1,
    ST_WAKE_HIGH = 4'h3,
    ST_IDLE = 4'h2,
    ST_ROW = 4'h6,
    ST_COL = 4'h7,
    ST_COL_HOLD = 4'h5,
    ST_PAGE_WAIT = 4'h4,
    ST_CAS_PRE = 4'hC,
    ST_PRECHARGE = 4'hD,
    ST_REFRESH = 4'hF
  } drh_state_type;

endpackage

// ==== rtl/drh_timer.sv ====
// down counter used for the strobe widths, precharges and power-up pause in the host
// assumes one clock; load wins over counting
`timescale 1ns/10ps
`default_nettype none
module drh_timer #(
  parameter int WIDTH = 16
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [WIDTH-1:0] value_i,
  output logic done_o
);

  logic [WIDTH-1:0] count;
  wire logic at_zero = (count == '0);

  // reload on request, otherwise count down and stick at zero
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      count <= '0;
    end else if (load_i) begin
      count <= value_i;
    end else if (!at_zero) begin
      count <= count - WIDTH'(1);
    end
  end

  // done depends on the count alone; gating it with load would close a loop through the caller
  assign done_o = at_zero;

endmodule // drh_timer
`default_nettype wire

// ==== bench/drh_dram_model.sv ====
// behavioural 64k x 1 dram answering the host strobes
// assumes pins come from drh_host; q is only meaningful while the column strobe is low
`timescale 1ns/10ps
`default_nettype none
module drh_dram_model #(
  parameter int ACCESS_NS = 60
) (
  input wire drh_pkg::drh_pins_type pins_i,
  output logic q_o,
  output logic bad_o,
  output int refresh_cnt_o
);
  logic mem [0:65535];
  logic [7:0] row;
  logic [7:0] col;
  logic col_seen;
  int wake;
  initial begin
    foreach (mem[i]) mem[i] = 1'b0;
    q_o = 1'b0;
    bad_o = 1'b0;
    refresh_cnt_o = 0;
    wake = 0;
    row = 8'h00;
    col_seen = 1'b0;
  end
  // row field latched as the row strobe falls; every fall is a wake cycle
  // address and strobe leave the host on one edge; let both settle before latching
  always @(negedge pins_i.ras_n) begin
    #1;
    row = pins_i.addr;
    wake = wake + 1;
    col_seen = 1'b0;
  end
  // standby on the rising row strobe; no column strobe means a refresh cycle
  always @(posedge pins_i.ras_n) begin
    if (!col_seen) refresh_cnt_o = refresh_cnt_o + 1;
  end
  // a column strobe without the row strobe low is ignored
  always @(negedge pins_i.cas_n) begin
    if (!pins_i.ras_n) begin
      col = pins_i.addr;
      col_seen = 1'b1;
      if (wake < 8) bad_o = 1'b1;
      if (!pins_i.write_n) mem[{row, col}] = pins_i.data_in;
      else begin
        #(ACCESS_NS);
        if (!pins_i.cas_n) q_o = mem[{row, col}];
      end
    end
  end
  // unlatched output: released line shows the inverse, never the old bit
  always @(posedge pins_i.cas_n) q_o = ~q_o;
endmodule  // drh_dram_model
`default_nettype wire

// ==== bench/drh_host_checker.sv ====
// strobe timing properties of the dram host
// assumes it is bound into drh_host and sees only its ports
`timescale 1ns/10ps
`default_nettype none
module drh_host_checker #(
  parameter int POWERUP_COUNT = 50,
  parameter int REFRESH_COUNT = 200,
  parameter int PAGE_COUNT = 300
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic req_ready_o,
  input wire logic init_done_o,
  input wire logic dram_ras_n_o,
  input wire logic dram_cas_n_o,
  input wire logic dram_write_n_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  int up_cnt;
  int wake_cnt;
  int hi_cnt;
  int lo_cnt;
  // cycles since reset, row strobe falls, and run lengths of each row strobe level
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      up_cnt <= 0;
      wake_cnt <= 0;
    end else begin
      up_cnt <= up_cnt + 1;
      wake_cnt <= wake_cnt + ($fell(dram_ras_n_o) ? 1 : 0);
    end
    hi_cnt <= dram_ras_n_o ? hi_cnt + 1 : 0;
    lo_cnt <= dram_ras_n_o ? 0 : lo_cnt + 1;
  end
  sequence s_ras_low;
    !dram_ras_n_o [*3];
  endsequence
  sequence s_ras_high;
    dram_ras_n_o [*3];
  endsequence
  AST_READY_AFTER_INIT: assert property (req_ready_o |-> init_done_o)
    else $error("ready before init done");
  AST_WAKE_COUNT: assert property ($rose(init_done_o) |-> wake_cnt >= 8)
    else $error("init done before eight wake cycles");
  AST_POWERUP_PAUSE: assert property
    ($fell(dram_ras_n_o) && wake_cnt == 0 |-> up_cnt >= POWERUP_COUNT)
    else $error("row strobe before power-up pause");
  AST_RAS_WIDTH: assert property ($fell(dram_ras_n_o) |-> s_ras_low)
    else $error("row strobe too short");
  AST_RAS_PRECHARGE: assert property ($rose(dram_ras_n_o) |-> s_ras_high)
    else $error("row precharge too short");
  AST_CAS_WIDTH: assert property ($fell(dram_cas_n_o) |-> !dram_cas_n_o [*2])
    else $error("column strobe too short");
  AST_CAS_AFTER_RAS: assert property
    ($fell(dram_cas_n_o) |-> !dram_ras_n_o && !$past(dram_ras_n_o))
    else $error("column strobe without row strobe lead");
  AST_CAS_OFF_AT_RAS_RISE: assert property ($rose(dram_ras_n_o) |-> dram_cas_n_o)
    else $error("column strobe overlaps precharge");
  AST_WRITE_STEADY: assert property
    (!dram_cas_n_o && !$past(dram_cas_n_o) |-> $stable(dram_write_n_o))
    else $error("write strobe moved under column strobe");
  AST_REFRESH_DUE: assert property (init_done_o |-> hi_cnt <= REFRESH_COUNT + 16)
    else $error("refresh interval exceeded");
  AST_PAGE_LIMIT: assert property (lo_cnt <= PAGE_COUNT)
    else $error("row strobe held too long");
endmodule  // drh_host_checker
bind drh_host drh_host_checker #(.POWERUP_COUNT(POWERUP_COUNT),
  .REFRESH_COUNT(REFRESH_COUNT), .PAGE_COUNT(PAGE_COUNT)) u_chk (.sys_clk_i, .rst_i,
  .req_ready_o, .init_done_o, .dram_ras_n_o, .dram_cas_n_o, .dram_write_n_o);
`default_nettype wire

// ==== bench/drh_host_tb.sv ====
// self-checking bench for drh_host with a behavioural dram
// assumes shortened timing counts; inputs change on the falling clock edge
`timescale 1ns/10ps
`default_nettype none
module drh_host_tb;
  localparam int PU = 50;
  localparam int RF = 200;
  // writes then reads; a read row carries its expected bit in the data field
  localparam drh_pkg::drh_req_type ROWS [10] = '{
    '{1'b1, 8'h00, 8'h00, 1'b1}, '{1'b1, 8'hFF, 8'hFF, 1'b1}, '{1'b1, 8'h80, 8'h01, 1'b1},
    '{1'b1, 8'h00, 8'h01, 1'b0}, '{1'b1, 8'h00, 8'hFF, 1'b0}, '{1'b0, 8'h00, 8'h00, 1'b1},
    '{1'b0, 8'hFF, 8'hFF, 1'b1}, '{1'b0, 8'h80, 8'h01, 1'b1}, '{1'b0, 8'h00, 8'h01, 1'b0},
    '{1'b0, 8'h00, 8'hFF, 1'b0}};
  logic sys_clk_i, rst_i, req_valid_i, page_i, dram_q_i, bad;
  logic req_ready_o, rd_valid_o, rd_data_o, init_done_o;
  logic dram_ras_n_o, dram_cas_n_o, dram_write_n_o, dram_data_o;
  logic [7:0] dram_addr_o;
  drh_pkg::drh_req_type req_i;
  drh_pkg::drh_pins_type pins;
  int n_errors = 0;
  int total_checks = 0;
  int refresh_cnt;
  int ref0;
  int f0;
  int ras_falls = 0;
  logic cas_q;
  assign pins = {dram_ras_n_o, dram_cas_n_o, dram_write_n_o, dram_addr_o, dram_data_o};
  // the cycle right after a column strobe rises with the row held is the page gap
  wire logic page_slot = dram_ras_n_o === 1'b0 && dram_cas_n_o === 1'b1 && cas_q === 1'b0;
  always @(posedge sys_clk_i) cas_q <= dram_cas_n_o;
  always @(negedge dram_ras_n_o) ras_falls++;
  drh_host #(.POWERUP_COUNT(PU), .IDLE_COUNT(400), .REFRESH_COUNT(RF), .PAGE_COUNT(300))
    u_dut (.sys_clk_i, .rst_i, .req_valid_i, .req_i, .page_i, .req_ready_o, .rd_valid_o,
    .rd_data_o, .init_done_o, .dram_ras_n_o, .dram_cas_n_o, .dram_write_n_o, .dram_addr_o,
    .dram_data_o, .dram_q_i);
  drh_dram_model u_mem (.pins_i(pins), .q_o(dram_q_i), .bad_o(bad), .refresh_cnt_o(refresh_cnt));
  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one request held for one taking edge; a page request may go in the page gap
  task automatic access(input drh_pkg::drh_req_type r, input logic pg);
    int n;
    n = 0;
    while (req_ready_o !== 1'b1 && !(pg && page_slot) && n < 2000) begin
      @(negedge sys_clk_i);
      n++;
    end
    req_valid_i = 1'b1;
    req_i = r;
    page_i = pg;
    @(negedge sys_clk_i);
    req_valid_i = 1'b0;
    // a page request turned down (refresh due or other row) is sent again once idle
    if (pg && dram_ras_n_o === 1'b1) begin
      while (req_ready_o !== 1'b1 && n < 4000) begin
        @(negedge sys_clk_i);
        n++;
      end
      req_valid_i = 1'b1;
      @(negedge sys_clk_i);
      req_valid_i = 1'b0;
    end
    if (!r.write) begin
      n = 0;
      while (rd_valid_o !== 1'b1 && n < 40) begin
        @(negedge sys_clk_i);
        n++;
      end
      chk("read valid", 8'h01, {7'h00, rd_valid_o === 1'b1});
      chk("read bit", {7'h00, r.data}, {7'h00, rd_data_o});
    end
  endtask
  // waits for init and checks that pause plus wake cycles were spent
  task automatic wait_init;
    int n;
    n = 0;
    while (init_done_o !== 1'b1 && n < 4000) begin
      @(negedge sys_clk_i);
      n++;
    end
    // pause, then eight wake cycles of at least one strobe width and one precharge each
    chk("init delay", 8'h01, {7'h00, n >= PU + 8 * (drh_pkg::RAS_MIN_CYCLES
      + drh_pkg::PRECHARGE_CYCLES) && init_done_o === 1'b1});
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // the run needs about a thousand cycles; 50000 means a hang
  initial begin
    #2000000;
    n_errors++;
    print_verdict;
  end
  initial begin
    rst_i = 1'b1;
    req_valid_i = 1'b0;
    req_i = '0;
    page_i = 1'b0;
    repeat (8) @(negedge sys_clk_i);
    chk("strobes in reset", 8'h07, {5'h00, dram_ras_n_o, dram_cas_n_o, dram_write_n_o});
    rst_i = 1'b0;
    wait_init;
    foreach (ROWS[i]) access(ROWS[i], 1'b0);
    // back-to-back page accesses on one row, mixing writes and reads
    f0 = ras_falls;
    access('{1'b1, 8'h12, 8'h34, 1'b1}, 1'b1);
    access('{1'b1, 8'h12, 8'h35, 1'b1}, 1'b1);
    access('{1'b0, 8'h12, 8'h34, 1'b1}, 1'b1);
    access('{1'b0, 8'h12, 8'h35, 1'b1}, 1'b1);
    // one row opening, plus at most one refresh and one reopening after it
    chk("row strobes in page", 8'h01, {7'h00, ras_falls - f0 <= 3});
    // idle long enough that only refresh cycles keep the rows alive
    ref0 = refresh_cnt;
    repeat (3 * RF) @(negedge sys_clk_i);
    chk("refresh cycles", 8'h01, {7'h00, refresh_cnt - ref0 >= 2});
    access('{1'b0, 8'h80, 8'h01, 1'b1}, 1'b0);
    // reset in mid-run forces strobes idle and repeats the wake sequence
    rst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    chk("ready in reset", 8'h06, {5'h00, dram_ras_n_o, dram_cas_n_o, req_ready_o});
    rst_i = 1'b0;
    wait_init;
    access('{1'b0, 8'hFF, 8'hFF, 1'b1}, 1'b0);
    chk("early column strobe", 8'h00, {7'h00, bad});
    print_verdict;
  end
endmodule  // drh_host_tb
`default_nettype wire
